/* atc_pkg.sv */
// package and basic-clock divider for the converter timing sequencer
`timescale 1ns/1ns

package atc_pkg;
  // -------------------------------------------------------------------
  // clock and widths
  // -------------------------------------------------------------------
  localparam int          CORE_CLK_MHZ  = 250;
  localparam int          RES_W         = 10;
  localparam int          RATIO_W       = 5;
  localparam int          TICK_W        = 7;
  localparam int          CAL_W         = 12;
  localparam int          CYC_W         = 12;

  // -------------------------------------------------------------------
  // divider ratios per conv_clock_select code
  // -------------------------------------------------------------------
  localparam logic [4:0]  DIV_CODE0     = 5'h04;
  localparam logic [4:0]  DIV_CODE1     = 5'h02;
  localparam logic [4:0]  DIV_CODE2     = 5'h10;
  localparam logic [4:0]  DIV_CODE3     = 5'h08;

  // -------------------------------------------------------------------
  // sample lengths per sample_time_select code, in basic periods
  // -------------------------------------------------------------------
  localparam logic [6:0]  SMP_CODE0     = 7'h08;
  localparam logic [6:0]  SMP_CODE1     = 7'h10;
  localparam logic [6:0]  SMP_CODE2     = 7'h20;
  localparam logic [6:0]  SMP_CODE3     = 7'h40;

  // -------------------------------------------------------------------
  // conversion sequence constants
  // -------------------------------------------------------------------
  localparam logic [6:0]  CONV_BC       = 7'h28;
  localparam logic [1:0]  BIT_SLOT_LAST = 2'h3;
  localparam logic [3:0]  MSB_IDX       = 4'h9;
  localparam logic [9:0]  TRIAL_INIT    = 10'h200;
  localparam logic [9:0]  RES_ZERO      = 10'h000;
  localparam logic [9:0]  RES_FULL      = 10'h3ff;
  localparam logic [11:0] WRITE_CYC     = 12'h002;
  localparam int          CAL_BC_DEF    = 3328;

  // converter_control_reg fields that this block uses
  typedef struct packed {
    logic [1:0] conv_clock_select;
    logic [1:0] sample_time_select;
  } atc_cfg_t;

  // comparator side of the analog core
  typedef struct packed {
    logic cmp_hi;
    logic below_gnd;
    logic above_ref;
  } atc_ana_t;

  // ratio decode, used by divider and checks
  function automatic logic [4:0] atc_ratio(input logic [1:0] code);
    case (code)
      2'h0:    atc_ratio = DIV_CODE0;
      2'h1:    atc_ratio = DIV_CODE1;
      2'h2:    atc_ratio = DIV_CODE2;
      default: atc_ratio = DIV_CODE3;
    endcase
  endfunction : atc_ratio

  // sample length decode
  function automatic logic [6:0] atc_smp(input logic [1:0] code);
    case (code)
      2'h0:    atc_smp = SMP_CODE0;
      2'h1:    atc_smp = SMP_CODE1;
      2'h2:    atc_smp = SMP_CODE2;
      default: atc_smp = SMP_CODE3;
    endcase
  endfunction : atc_smp
endpackage : atc_pkg

// basic clock as an enable pulse, restartable
module atc_div (
  input  wire logic       core_clk,  // cpu clock
  input  wire logic       srst,      // sync reset
  input  wire logic       clr,       // restart the period
  input  wire logic [4:0] ratio,     // cpu cycles per period
  output logic            tick       // last cycle of a period
);
  import atc_pkg::*;

  logic [4:0] cnt_q;
  logic [4:0] cnt_d;

  // period end when counter reaches ratio-1
  assign tick = (cnt_q == 5'(ratio - 5'h01));

  // next count
  always_comb begin
    if (clr || tick) begin
      cnt_d = 5'h00;
    end else begin
      cnt_d = 5'(cnt_q + 5'h01);
    end
  end

  // counter register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : atc_div

/* atc_seq.sv */
// converter timing sequencer: sample, bit decisions, write, calibration
`timescale 1ns/1ns

module atc_seq #(
  parameter int CAL_BC_PERIODS = atc_pkg::CAL_BC_DEF // basic periods
) (
  input  wire logic            core_clk,     // cpu clock, 250 mhz
  input  wire logic            srst,         // sync reset, active high
  input  atc_pkg::atc_cfg_t    cfg,          // converter_control_reg fields
  input  wire logic            start,        // conversion request pulse
  input  atc_pkg::atc_ana_t    ana,          // comparator and range flags
  output logic                 sample_en,    // sample switch closed
  output logic                 hold,         // input held
  output logic [9:0]           dac_code,     // trial code to the core
  output logic                 busy,         // conversion running
  output logic                 cal_busy,     // calibration running
  output logic [9:0]           result_q,     // conversion result
  output logic                 result_valid  // result written, one cycle
);
  import atc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SAMPLE, ST_CONV, ST_WR1, ST_WR2
  } atc_state_t;

  localparam logic [11:0] CAL_LAST = 12'(CAL_BC_PERIODS - 1);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  atc_state_t       st_q, st_d;
  atc_cfg_t         cfg_q, cfg_d;
  logic [6:0]       tcnt_q, tcnt_d;
  logic [3:0]       bit_q, bit_d;
  logic [9:0]       trial_q, trial_d;
  logic             below_q, below_d;
  logic             above_q, above_d;
  logic [9:0]       res_d;
  logic             rv_q, rv_d;
  logic [11:0]      cal_q, cal_d;
  logic             calb_q, calb_d;
  logic             div_tick;
  logic [4:0]       ratio;
  logic [6:0]       smp_len;
  logic             go;

  assign go      = (st_q == ST_IDLE) && start;
  assign ratio   = atc_ratio(cfg_q.conv_clock_select);
  assign smp_len = atc_smp(cfg_q.sample_time_select);

  // basic clock, restarted at each accepted request
  atc_div u_div (
    .core_clk (core_clk),
    .srst     (srst),
    .clr      (go),
    .ratio    (ratio),
    .tick     (div_tick)
  );

  // -------------------------------------------------------------------
  // sequencer next state
  // -------------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    cfg_d   = cfg_q;
    tcnt_d  = tcnt_q;
    bit_d   = bit_q;
    trial_d = trial_q;
    below_d = below_q;
    above_d = above_q;
    res_d   = result_q;
    rv_d    = 1'b0;
    case (st_q)
      ST_IDLE: begin
        // settings follow the register only between conversions
        cfg_d  = cfg;
        tcnt_d = 7'h00;
        if (start) begin
          cfg_d = cfg;
          st_d  = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (div_tick) begin
          tcnt_d = 7'(tcnt_q + 7'h01);
          if (tcnt_q == 7'(smp_len - 7'h01)) begin
            st_d    = ST_CONV;
            tcnt_d  = 7'h00;
            bit_d   = MSB_IDX;
            trial_d = TRIAL_INIT;
            below_d = ana.below_gnd;
            above_d = ana.above_ref;
          end
        end
      end
      ST_CONV: begin
        if (div_tick) begin
          tcnt_d = 7'(tcnt_q + 7'h01);
          // one bit decided every fourth basic period
          if (tcnt_q[1:0] == BIT_SLOT_LAST) begin
            trial_d[bit_q] = ana.cmp_hi;
            if (bit_q != 4'h0) begin
              trial_d[bit_q - 4'h1] = 1'b1;
              bit_d = 4'(bit_q - 4'h1);
            end
          end
          if (tcnt_q == 7'(CONV_BC - 7'h01)) begin
            st_d = ST_WR1;
          end
        end
      end
      ST_WR1: begin
        st_d = ST_WR2;
      end
      ST_WR2: begin
        // out of range inputs clamp the result
        if (below_q) begin
          res_d = RES_ZERO;
        end else if (above_q) begin
          res_d = RES_FULL;
        end else begin
          res_d = trial_q;
        end
        rv_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q     <= ST_IDLE;
      cfg_q    <= '0;
      tcnt_q   <= 7'h00;
      bit_q    <= 4'h0;
      trial_q  <= 10'h000;
      below_q  <= 1'b0;
      above_q  <= 1'b0;
      result_q <= 10'h000;
      rv_q     <= 1'b0;
    end else begin
      st_q     <= st_d;
      cfg_q    <= cfg_d;
      tcnt_q   <= tcnt_d;
      bit_q    <= bit_d;
      trial_q  <= trial_d;
      below_q  <= below_d;
      above_q  <= above_d;
      result_q <= res_d;
      rv_q     <= rv_d;
    end
  end

  // -------------------------------------------------------------------
  // calibration
  // -------------------------------------------------------------------
  always_comb begin
    cal_d  = cal_q;
    calb_d = calb_q;
    // periods count only while no conversion runs
    if (calb_q && (st_q == ST_IDLE) && !start && div_tick) begin
      cal_d = 12'(cal_q + 12'h001);
      if (cal_q == CAL_LAST) begin
        calb_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cal_q  <= 12'h000;
      calb_q <= 1'b1;
    end else begin
      cal_q  <= cal_d;
      calb_q <= calb_d;
    end
  end

  // outputs
  assign sample_en    = (st_q == ST_SAMPLE);
  assign hold         = (st_q == ST_CONV) || (st_q == ST_WR1) ||
                        (st_q == ST_WR2);
  assign dac_code     = trial_q;
  assign busy         = (st_q != ST_IDLE);
  assign cal_busy     = calb_q;
  assign result_valid = rv_q;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  logic [11:0] cyc_q;
  logic [11:0] exp_q;

  // cycles since request, and the expected total
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cyc_q <= 12'h000;
      exp_q <= 12'h000;
    end else if (go) begin
      cyc_q <= 12'h000;
      exp_q <= 12'(({5'h00, atc_smp(cfg.sample_time_select)} + 12'(CONV_BC))
               * {7'h00, atc_ratio(cfg.conv_clock_select)} + WRITE_CYC);
    end else if (busy) begin
      cyc_q <= 12'(cyc_q + 12'h001);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // a tick in the last write cycle (divide by 2) or last conversion cycle (divide by 4) may be cut by a back-to-back restart
  a_div_by_two: assert property (busy && div_tick && ratio == DIV_CODE1
    && st_q != ST_WR2 |=> !div_tick ##1 div_tick)
    else $error("basic clock wrong for divide by 2");
  a_div_by_four: assert property (busy && div_tick && ratio == DIV_CODE0
    && st_d != ST_WR1 |=> !div_tick [*3] ##1 div_tick)
    else $error("basic clock wrong for divide by 4");
  a_sample_len: assert property ($rose(st_q == ST_CONV)
    |-> $past(tcnt_q) == 7'(smp_len - 7'h01))
    else $error("sample phase length wrong");
  a_conv_total: assert property (st_q == ST_WR2
    |-> 12'(cyc_q + 12'h001) == exp_q)
    else $error("conversion total time wrong");
  a_cal_len: assert property ($fell(calb_q)
    |-> $past(cal_q) == CAL_LAST)
    else $error("calibration length wrong");
  a_cal_extend: assert property (calb_q && busy
    |=> $stable(cal_q))
    else $error("calibration advanced during conversion");
  a_clamp_low: assert property (st_q == ST_WR2 && below_q
    |=> result_valid && result_q == RES_ZERO)
    else $error("below ground not clamped to zero");
  a_clamp_high: assert property (st_q == ST_WR2 && !below_q && above_q
    |=> result_valid && result_q == RES_FULL)
    else $error("above reference not clamped to full scale");
  a_hold_input: assert property ($rose(st_q == ST_CONV)
    |-> hold && !sample_en ##1 $stable(below_q))
    else $error("input not held after sample phase");
  a_write_slot: assert property (result_valid
    |-> $past(st_q, 1) == ST_WR2 && $past(st_q, 2) == ST_WR1)
    else $error("result written outside final cycles");

  c_conv_done: cover property (go ##[1:1000] result_valid);
  c_conv_in_cal: cover property (calb_q && go);
  c_cal_done: cover property ($fell(calb_q));
endmodule : atc_seq

/* atc_ana_model.sv */
// behavioural analog input and comparator model for the sequencer
`timescale 1ns/1ns

module atc_ana_model (
  input  wire logic        core_clk,   // cpu clock
  input  wire logic        sample_en,  // sample switch closed
  input  wire logic [9:0]  dac_code,   // trial code from sequencer
  input  int               ain,        // input level, lsb units
  output atc_pkg::atc_ana_t ana        // comparator and range flags
);
  import atc_pkg::*;

  int held = 0;

  // track the input only while the switch is closed
  always @(posedge core_clk) begin
    if (sample_en) begin
      held <= ain;
    end
  end

  // compare held level with trial code, flag out-of-range levels
  always_comb begin
    ana.cmp_hi    = (held >= int'(dac_code));
    ana.below_gnd = (held < 0);
    ana.above_ref = (held > 1023);
  end
endmodule : atc_ana_model

/* atc_tb.sv */
// self-checking testbench for the converter timing sequencer
`timescale 1ns/1ns

module tb_top;
  import atc_pkg::*;

  localparam int CAL = 4;

  logic       core_clk;
  logic       srst;
  atc_cfg_t   cfg;
  logic       start;
  atc_ana_t   ana;
  logic       sample_en;
  logic       hold;
  logic [9:0] dac_code;
  logic       busy;
  logic       cal_busy;
  logic [9:0] result_q;
  logic       result_valid;
  int         ain;
  int         err_total;
  int         num_checks;
  bit         pend;
  int         rt[4] = '{4, 2, 16, 8};
  int         st[4] = '{8, 16, 32, 64};

  atc_seq #(.CAL_BC_PERIODS(CAL)) u_dut (
    .core_clk    (core_clk),
    .srst        (srst),
    .cfg         (cfg),
    .start       (start),
    .ana         (ana),
    .sample_en   (sample_en),
    .hold        (hold),
    .dac_code    (dac_code),
    .busy        (busy),
    .cal_busy    (cal_busy),
    .result_q    (result_q),
    .result_valid(result_valid)
  );

  atc_ana_model u_ana (
    .core_clk (core_clk),
    .sample_en(sample_en),
    .dac_code (dac_code),
    .ain      (ain),
    .ana      (ana)
  );

  // --------------------------------------------------------------
  // clock
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  // one conversion: optional refused poke, late input change, chaining
  task automatic conv(input atc_cfg_t c, input int v, input int late,
                      input bit poke, input bit go, input atc_cfg_t nc,
                      input int nv);
    int n;
    int r;
    int s;
    int nexp;
    logic [9:0] er;
    n = 0;
    r = rt[c.conv_clock_select];
    s = st[c.sample_time_select];
    nexp = (s + 40) * r + 2;
    er = (v < 0) ? 10'h000 : ((v > 1023) ? 10'h3ff : 10'(v));
    if (!pend) begin
      @(posedge core_clk);
      cfg <= c;
      ain <= v;
      start <= 1'b1;
    end
    @(posedge core_clk);
    start <= 1'b0;
    repeat (2000) begin
      @(posedge core_clk);
      n++;
      if (n == 3 && poke) start <= 1'b1;
      if (n == 4) start <= 1'b0;
      if (n == s * r + 2) ain <= late;
      if (n == nexp && go) begin
        cfg <= nc;
        ain <= nv;
        start <= 1'b1;
      end
      #1;
      if (n == 3) chk("busy", 16'h1, {15'h0, busy});
      if (n == 3) chk("sample", 16'h1, {15'h0, sample_en});
      if (n == s * r + 2) chk("hold", 16'h1, {15'h0, hold});
      if (n == s * r + 2) chk("smp_off", 16'h0, {15'h0, sample_en});
      if (n == s * r + 2) chk("trial0", 16'h200, {6'h0, dac_code});
      if (result_valid === 1'b1) break;
    end
    pend = go;
    chk("latency", 16'(nexp), 16'(n));
    chk("idle", 16'h0, {15'h0, busy});
    chk("result", {6'h0, er}, {6'h0, result_q});
    if (result_valid !== 1'b1) begin
      err_total++;
      results();
    end
  endtask : conv

  // reset, optional conversion at once, then time calibration end
  task automatic cal_run(input bit go);
    int n;
    int lo;
    n = 0;
    lo = go ? (CAL - 2) * 4 : (CAL - 1) * 4;
    @(posedge core_clk);
    srst <= 1'b1;
    cfg <= '0;
    start <= 1'b0;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk("cal_rst", 16'h1, {15'h0, cal_busy});
    if (go) begin
      conv(atc_cfg_t'(4'h0), 300, 300, 1'b0, 1'b0, '0, 0);
      chk("cal_ext", 16'h1, {15'h0, cal_busy});
    end
    while (cal_busy === 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
      #1;
    end
    chk("cal_lo", 16'h1, {15'h0, n >= lo});
    chk("cal_hi", 16'h1, {15'h0, n <= CAL * 4 + 6});
    if (cal_busy !== 1'b0) begin
      err_total++;
      results();
    end
  endtask : cal_run

  // every clock select and sample time code, chained back to back
  task automatic sweep();
    for (int i = 0; i < 16; i++) begin
      conv(atc_cfg_t'(4'(i)), i * 61 + 5, 3, 1'b0, i < 15,
           atc_cfg_t'(4'(i + 1)), (i + 1) * 61 + 5);
    end
  endtask : sweep

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    srst = 1'b1;
    cfg = '0;
    start = 1'b0;
    ain = 0;
    err_total = 0;
    num_checks = 0;
    pend = 1'b0;
    cal_run(1'b0);
    cal_run(1'b1);
    conv(atc_cfg_t'(4'h0), 700, 5, 1'b1, 1'b0, '0, 0);
    conv(atc_cfg_t'(4'h5), -20, 500, 1'b0, 1'b0, '0, 0);
    conv(atc_cfg_t'(4'h5), 2000, 500, 1'b0, 1'b0, '0, 0);
    conv(atc_cfg_t'(4'h1), 1023, 0, 1'b0, 1'b0, '0, 0);
    sweep();
    results();
  end
endmodule : tb_top
